// >>> core/ipm_params.svh
// Constants for the interrupt and power mode controller
`ifndef IPM_PARAMS_SVH
`define IPM_PARAMS_SVH
// Register indices on the plain register port
`define IPM_ADDR_ENABLE   4'h0
`define IPM_ADDR_PRIO     4'h1
`define IPM_ADDR_TRIG     4'h2
`define IPM_ADDR_FLAGS    4'h3
`define IPM_ADDR_PCTRL    4'h4
`define IPM_ADDR_STATUS   4'h5
`define IPM_ADDR_VECT     4'h6
// Enable register fields
`define IPM_EN_GLOBAL     7
`define IPM_EN_NVM        5
// Flag bit positions
`define IPM_F_EXT_A       0
`define IPM_F_TMR_A       1
`define IPM_F_EXT_B       2
`define IPM_F_TMR_B       3
`define IPM_F_SER_RX      4
`define IPM_F_SER_TX      5
`define IPM_F_NVM         6
// Power control fields
`define IPM_PC_IDLE       0
`define IPM_PC_PDOWN      1
// Number of interrupt vectors
`define IPM_NVEC          5
// Vector program addresses
`define IPM_VEC_ADDR_0    16'h0003
`define IPM_VEC_ADDR_1    16'h000b
`define IPM_VEC_ADDR_2    16'h0013
`define IPM_VEC_ADDR_3    16'h001b
`define IPM_VEC_ADDR_4    16'h0023
// Latency bounds at the reference 12 MHz crystal, in ns
`define IPM_LAT_MIN_NS    3000
`define IPM_LAT_MAX_NS    7000
`define IPM_CLK_NS        10
// Reset values
`define IPM_RST_BYTE      8'h00
`endif

// >>> core/ipm_pkg.sv
// Types for the interrupt and power mode controller
package ipm_pkg;
   typedef enum logic [1:0] {
      IPM_RUN   = 2'b00,
      IPM_IDLE  = 2'b01,
      IPM_PDOWN = 2'b10
   } ipm_mode_t;
endpackage

// >>> core/ipm_lat_timer.sv
// Response delay counter between a chosen request and vector delivery
`timescale 1ns/1ns
`include "ipm_params.svh"
module ipm_lat_timer #(
   parameter int MIN_CYC = 300,        // Least delay in cycles
   parameter int CW      = 10          // Counter width
) (
   input  wire logic sys_clk,          // System clock
   input  wire logic rst,              // Synchronous reset
   input  wire logic run,              // Hold high while a request waits
   output logic      done_q            // High once the least delay elapsed
);
   logic [CW-1:0] cnt_q;

   // Count while a request waits; restart whenever it drops
   always_ff @(posedge sys_clk) begin
      if (rst || !run) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else if (!done_q) begin
         cnt_q  <= cnt_q + 1'b1;
         done_q <= (cnt_q == CW'(MIN_CYC - 2));
      end
   end
endmodule

// >>> core/ipm_ctrl.sv
// Interrupt controller with idle and power-down pin control
//
// Notes on behaviour
// - Power-down stops the oscillator after request
// - Only RAM and memory contents survive
// - Only hardware reset ends power-down
// - Nested two-level interrupts, asynchronous to code
// - Request to service within latency window
// - Seven request sources accepted
// - Serial and memory requests share vector
// - Each vector has fixed program address
// - Per-source enables; memory needs serial enable
// - Per-source high or low priority
// - Global enable masks all sources
// - External pins active low, level option
// - Hardware clears timer and edge-mode external flags
// - Strobe and port states in low power
// - Enabled interrupt or reset ends idle
`timescale 1ns/1ns
`include "ipm_params.svh"
module ipm_ctrl #(
   parameter int LAT_MIN_CYC = (`IPM_LAT_MIN_NS + `IPM_CLK_NS - 1) / `IPM_CLK_NS,
   parameter int LAT_MAX_CYC = `IPM_LAT_MAX_NS / `IPM_CLK_NS
) (
   input  wire logic        sys_clk,             // 100 MHz system clock
   input  wire logic        rst,                 // Synchronous reset, active high
   input  wire logic [3:0]  reg_addr,            // Register index
   input  wire logic [7:0]  reg_wdata,           // Write data
   input  wire logic        reg_wr,              // Write strobe
   input  wire logic        reg_rd,              // Read strobe
   output logic      [7:0]  reg_rdata,           // Read data, cycle after strobe
   input  wire logic        ext_irq_a_n,         // External request A, active low
   input  wire logic        ext_irq_b_n,         // External request B, active low
   input  wire logic        tmr_a_ovf,           // Timer A overflow pulse
   input  wire logic        tmr_b_ovf,           // Timer B overflow pulse
   input  wire logic        ser_rx_done,         // Serial receive pulse
   input  wire logic        ser_tx_done,         // Serial transmit pulse
   input  wire logic        nvm_done,            // Memory write finished pulse
   input  wire logic        ext_prog_mem,        // Program runs from external memory
   input  wire logic        cpu_ack,             // Core takes offered vector
   input  wire logic        cpu_reti,            // Core returns from service
   output logic             irq_req_q,           // Vector offered to core
   output logic      [2:0]  irq_vec_q,           // Offered vector number
   output logic      [15:0] irq_addr_q,          // Offered service address
   output logic             osc_run_q,           // Oscillator enable
   output logic             cpu_run_q,           // Core clock enable
   output logic             addr_latch_q,        // Address latch strobe
   output logic             prog_fetch_strobe_n_q, // Program fetch strobe, active low
   output logic             port0_float_q,       // Port 0 released
   output logic             port2_addr_q        // Port 2 drives address
);
   logic [7:0]         en_q, prio_q, trig_q, flags_q;
   logic [7:0]         flag_set, flag_clr_hw;
   logic               ext_a_q, ext_b_q;
   ipm_pkg::ipm_mode_t mode_q;
   logic [1:0]         act_q;                   // Bit 1 high level, bit 0 low level active
   logic [`IPM_NVEC-1:0] vreq, vhi;
   logic               pick_ok, pick_hi, wait_done;
   logic [2:0]         pick;
   logic [9:0]         wait_cnt_q;

   // Vector address table
   function automatic logic [15:0] vec_addr(input logic [2:0] v);
      unique case (v)
         3'h0:    vec_addr = `IPM_VEC_ADDR_0;
         3'h1:    vec_addr = `IPM_VEC_ADDR_1;
         3'h2:    vec_addr = `IPM_VEC_ADDR_2;
         3'h3:    vec_addr = `IPM_VEC_ADDR_3;
         3'h4:    vec_addr = `IPM_VEC_ADDR_4;
         default: vec_addr = `IPM_VEC_ADDR_0;
      endcase
   endfunction

   // Flag index for a single-flag vector
   function automatic int flag_of(input int v);
      unique case (v)
         0:       flag_of = `IPM_F_EXT_A;
         1:       flag_of = `IPM_F_TMR_A;
         2:       flag_of = `IPM_F_EXT_B;
         default: flag_of = `IPM_F_TMR_B;
      endcase
   endfunction

   // Register the active-low pins once; inputs are synchronous already
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ext_a_q <= 1'b0;
         ext_b_q <= 1'b0;
      end else begin
         ext_a_q <= ~ext_irq_a_n;
         ext_b_q <= ~ext_irq_b_n;
      end
   end

   // Trig bit high selects falling edge, low selects level
   always_comb begin
      flag_set = '0;
      flag_set[`IPM_F_EXT_A]  = trig_q[0] ? (~ext_irq_a_n & ~ext_a_q) : ~ext_irq_a_n;
      flag_set[`IPM_F_EXT_B]  = trig_q[1] ? (~ext_irq_b_n & ~ext_b_q) : ~ext_irq_b_n;
      flag_set[`IPM_F_TMR_A]  = tmr_a_ovf;
      flag_set[`IPM_F_TMR_B]  = tmr_b_ovf;
      flag_set[`IPM_F_SER_RX] = ser_rx_done;
      flag_set[`IPM_F_SER_TX] = ser_tx_done;
      flag_set[`IPM_F_NVM]    = nvm_done;
   end

   // Vector requests: enable per source under global enable
   generate
      for (genvar v = 0; v < 4; v++) begin : g_single
         assign vreq[v] = flags_q[flag_of(v)] & en_q[v] & en_q[`IPM_EN_GLOBAL];
         assign vhi[v]  = prio_q[v];
      end
   endgenerate
   // Serial and memory share the last vector; memory also needs serial enable
   assign vreq[4] = en_q[`IPM_EN_GLOBAL] & en_q[4] &
                    (flags_q[`IPM_F_SER_RX] | flags_q[`IPM_F_SER_TX] |
                     (flags_q[`IPM_F_NVM] & en_q[`IPM_EN_NVM]));
   assign vhi[4]  = prio_q[4];

   // Pick highest level first, then lowest vector number
   always_comb begin
      pick_ok = 1'b0;
      pick_hi = 1'b0;
      pick    = 3'h0;
      for (int v = `IPM_NVEC - 1; v >= 0; v--) begin
         if (vreq[v] && vhi[v] && !act_q[1]) begin
            pick_ok = 1'b1;
            pick_hi = 1'b1;
            pick    = 3'(v);
         end
      end
      if (!pick_ok) begin
         for (int v = `IPM_NVEC - 1; v >= 0; v--) begin
            if (vreq[v] && !vhi[v] && act_q == 2'b00) begin
               pick_ok = 1'b1;
               pick    = 3'(v);
            end
         end
      end
   end

   // Least response delay before a vector is offered
   ipm_lat_timer #(
      .MIN_CYC (LAT_MIN_CYC),
      .CW      (10)
   ) u_lat (
      .sys_clk (sys_clk),
      .rst     (rst),
      .run     (pick_ok && !irq_req_q && mode_q != ipm_pkg::IPM_PDOWN),
      .done_q  (wait_done)
   );

   // Hardware clears timer and edge flags on acceptance; set beats clear
   always_comb begin
      flag_clr_hw = '0;
      if (irq_req_q && cpu_ack && irq_vec_q < 3'h4) begin
         unique case (irq_vec_q)
            3'h0:    flag_clr_hw[`IPM_F_EXT_A] = trig_q[0];
            3'h1:    flag_clr_hw[`IPM_F_TMR_A] = 1'b1;
            3'h2:    flag_clr_hw[`IPM_F_EXT_B] = trig_q[1];
            default: flag_clr_hw[`IPM_F_TMR_B] = 1'b1;
         endcase
      end
   end

   // Flags; level inputs track the pin, software may clear any flag but a level-mode external one
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flags_q <= `IPM_RST_BYTE;
      end else begin
         flags_q <= flag_set | (flags_q & ~flag_clr_hw &
                    ~((reg_wr && reg_addr == `IPM_ADDR_FLAGS) ? reg_wdata : 8'h00));
         if (!trig_q[0]) begin
            flags_q[`IPM_F_EXT_A] <= ~ext_irq_a_n;
         end
         if (!trig_q[1]) begin
            flags_q[`IPM_F_EXT_B] <= ~ext_irq_b_n;
         end
      end
   end

   // Software registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         en_q   <= `IPM_RST_BYTE;
         prio_q <= `IPM_RST_BYTE;
         trig_q <= `IPM_RST_BYTE;
      end else if (reg_wr) begin
         unique case (reg_addr)
            `IPM_ADDR_ENABLE: en_q   <= reg_wdata;
            `IPM_ADDR_PRIO:   prio_q <= reg_wdata;
            `IPM_ADDR_TRIG:   trig_q <= reg_wdata;
            default:          ;
         endcase
      end
   end

   // Vector offer, held until the core takes it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_req_q  <= 1'b0;
         irq_vec_q  <= 3'h0;
         irq_addr_q <= 16'h0000;
      end else if (irq_req_q) begin
         if (cpu_ack) begin
            irq_req_q <= 1'b0;
         end
      end else if (wait_done && pick_ok && mode_q != ipm_pkg::IPM_PDOWN) begin
         irq_req_q  <= 1'b1;
         irq_vec_q  <= pick;
         irq_addr_q <= vec_addr(pick);
      end
   end

   // Active levels: set on take, drop highest on return
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         act_q <= 2'b00;
      end else if (irq_req_q && cpu_ack) begin
         act_q[vhi[irq_vec_q]] <= 1'b1;
      end else if (cpu_reti) begin
         if (act_q[1]) begin
            act_q[1] <= 1'b0;
         end else begin
            act_q[0] <= 1'b0;
         end
      end
   end

   // Power mode; power-down has no exit but reset, which also wipes all this
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_q <= ipm_pkg::IPM_RUN;
      end else begin
         unique case (mode_q)
            ipm_pkg::IPM_RUN: begin
               if (reg_wr && reg_addr == `IPM_ADDR_PCTRL) begin
                  if (reg_wdata[`IPM_PC_PDOWN]) begin
                     mode_q <= ipm_pkg::IPM_PDOWN;
                  end else if (reg_wdata[`IPM_PC_IDLE]) begin
                     mode_q <= ipm_pkg::IPM_IDLE;
                  end
               end
            end
            ipm_pkg::IPM_IDLE: begin
               if (irq_req_q) begin
                  mode_q <= ipm_pkg::IPM_RUN;
               end
            end
            ipm_pkg::IPM_PDOWN: mode_q <= ipm_pkg::IPM_PDOWN;
            default:            mode_q <= ipm_pkg::IPM_RUN;
         endcase
      end
   end

   // Pin states; the request write is the last thing the core does
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         osc_run_q             <= 1'b1;
         cpu_run_q             <= 1'b1;
         addr_latch_q          <= 1'b1;
         prog_fetch_strobe_n_q <= 1'b1;
         port0_float_q         <= 1'b0;
         port2_addr_q          <= 1'b0;
      end else begin
         osc_run_q             <= (mode_q != ipm_pkg::IPM_PDOWN);
         cpu_run_q             <= (mode_q == ipm_pkg::IPM_RUN);
         addr_latch_q          <= (mode_q != ipm_pkg::IPM_PDOWN);
         prog_fetch_strobe_n_q <= (mode_q != ipm_pkg::IPM_PDOWN);
         port0_float_q         <= ext_prog_mem && mode_q != ipm_pkg::IPM_RUN;
         port2_addr_q          <= ext_prog_mem && mode_q != ipm_pkg::IPM_PDOWN;
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst || !reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         unique case (reg_addr)
            `IPM_ADDR_ENABLE: reg_rdata <= en_q;
            `IPM_ADDR_PRIO:   reg_rdata <= prio_q;
            `IPM_ADDR_TRIG:   reg_rdata <= trig_q;
            `IPM_ADDR_FLAGS:  reg_rdata <= flags_q;
            `IPM_ADDR_STATUS: reg_rdata <= {4'h0, act_q, mode_q};
            `IPM_ADDR_VECT:   reg_rdata <= {4'h0, irq_req_q, irq_vec_q};
            default:          reg_rdata <= 8'h00;
         endcase
      end
   end

   // Cycles a chosen request waits before it is offered; held at zero in
   // power-down, where no offer is ever made and the bound would trip
   always_ff @(posedge sys_clk) begin
      if (rst || !pick_ok || irq_req_q || mode_q == ipm_pkg::IPM_PDOWN) begin
         wait_cnt_q <= 10'h000;
      end else if (wait_cnt_q != 10'h3ff) begin
         wait_cnt_q <= wait_cnt_q + 10'h001;
      end
   end

   a_pdown_sticky: assert property (@(posedge sys_clk) disable iff (rst)
      mode_q == ipm_pkg::IPM_PDOWN |=> mode_q == ipm_pkg::IPM_PDOWN)
      else $error("power-down left without reset");

   a_osc_stops: assert property (@(posedge sys_clk) disable iff (rst)
      mode_q == ipm_pkg::IPM_PDOWN |=> !osc_run_q)
      else $error("oscillator still running in power-down");

   a_pdown_pins: assert property (@(posedge sys_clk) disable iff (rst)
      $past(mode_q) == ipm_pkg::IPM_PDOWN |-> !addr_latch_q && !prog_fetch_strobe_n_q)
      else $error("strobes not low in power-down");

   a_idle_pins: assert property (@(posedge sys_clk) disable iff (rst)
      $past(mode_q) == ipm_pkg::IPM_IDLE |-> addr_latch_q && prog_fetch_strobe_n_q)
      else $error("strobes not high in idle");

   a_lat_min: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(irq_req_q) |-> $past(wait_cnt_q) >= 10'(LAT_MIN_CYC - 1))
      else $error("vector offered too early");

   a_lat_max: assert property (@(posedge sys_clk) disable iff (rst)
      wait_cnt_q <= 10'(LAT_MAX_CYC))
      else $error("vector offered too late");

   a_addr_match: assert property (@(posedge sys_clk) disable iff (rst)
      irq_req_q |-> irq_addr_q == vec_addr(irq_vec_q))
      else $error("service address does not match vector");

   a_global_mask: assert property (@(posedge sys_clk) disable iff (rst)
      !en_q[`IPM_EN_GLOBAL] |-> !pick_ok)
      else $error("request chosen while globally masked");

   a_tmr_clear: assert property (@(posedge sys_clk) disable iff (rst)
      irq_req_q && cpu_ack && irq_vec_q == 3'h1 && !tmr_a_ovf |=> !flags_q[`IPM_F_TMR_A])
      else $error("timer flag not cleared on take");

   a_nest_hold: assert property (@(posedge sys_clk) disable iff (rst)
      act_q[1] |-> !pick_ok)
      else $error("request chosen during high level service");

   a_idle_wake: assert property (@(posedge sys_clk) disable iff (rst)
      mode_q == ipm_pkg::IPM_IDLE && irq_req_q |=> mode_q == ipm_pkg::IPM_RUN)
      else $error("idle not ended by interrupt");
endmodule

// >>> tb/ipm_cpu_model.sv
// Core sequencer model that takes offered vectors and returns from service
`timescale 1ns/1ns
module ipm_cpu_model (
   input  wire logic       sys_clk,    // System clock
   input  wire logic       rst,        // Synchronous reset
   input  wire logic       irq_req_q,  // Vector offered by the controller
   input  wire logic [1:0] ack_dly,    // Cycles to wait before taking it
   input  wire logic       reti_cmd,   // Bench asks for a return
   output logic            cpu_ack,    // Takes the offered vector
   output logic            cpu_reti    // Returns from the current routine
);
   logic [1:0] wait_q;

   // Take an offer after a chosen delay; the ack low gate stops a second take
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cpu_ack <= 1'b0;
         wait_q  <= 2'h0;
      end else if (irq_req_q && !cpu_ack) begin
         if (wait_q == ack_dly) begin
            cpu_ack <= 1'b1;
            wait_q  <= 2'h0;
         end else begin
            wait_q <= wait_q + 2'h1;
         end
      end else begin
         cpu_ack <= 1'b0;
         wait_q  <= 2'h0;
      end
   end

   // Returns only when told, so the innermost routine always ends first
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cpu_reti <= 1'b0;
      end else begin
         cpu_reti <= reti_cmd;
      end
   end
endmodule

// >>> tb/interrupt_and_power_mode_control_tb_top.sv
// Self-checking bench for the interrupt and power mode controller
`timescale 1ns/1ns
`include "ipm_params.svh"
module interrupt_and_power_mode_control_tb_top;
   localparam int LMIN = 4;   // Shortened least response delay
   localparam int LMAX = 20;  // Shortened greatest response delay
   typedef struct packed {
      logic [7:0]  en;
      logic [2:0]  vec;
      logic [15:0] addr;
      logic [7:0]  flg;
      logic [1:0]  dly;
   } ipm_row_t;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        ext_prog_mem = 1'b0;
   logic        reti_cmd = 1'b0;
   logic [1:0]  ack_dly = 2'h0;
   logic [6:0]  src = 7'h00;
   wire  [7:0]  reg_rdata;
   wire         irq_req_q, cpu_ack, cpu_reti, osc_run_q, cpu_run_q;
   wire  [2:0]  irq_vec_q;
   wire  [15:0] irq_addr_q;
   wire         addr_latch_q, prog_fetch_strobe_n_q, port0_float_q, port2_addr_q;
   wire  [4:0]  pins = {osc_run_q, addr_latch_q, prog_fetch_strobe_n_q,
                        port0_float_q, port2_addr_q};
   int          num_errors = 0;
   int          comparisons = 0;
   ipm_row_t    rows [7];

   always #5 sys_clk = ~sys_clk;

   // Source bits follow the flag positions; external pins are active low
   ipm_ctrl #(.LAT_MIN_CYC(LMIN), .LAT_MAX_CYC(LMAX)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_irq_a_n(~src[0]), .ext_irq_b_n(~src[2]), .tmr_a_ovf(src[1]),
      .tmr_b_ovf(src[3]), .ser_rx_done(src[4]), .ser_tx_done(src[5]),
      .nvm_done(src[6]), .ext_prog_mem(ext_prog_mem), .cpu_ack(cpu_ack),
      .cpu_reti(cpu_reti), .irq_req_q(irq_req_q), .irq_vec_q(irq_vec_q),
      .irq_addr_q(irq_addr_q), .osc_run_q(osc_run_q), .cpu_run_q(cpu_run_q),
      .addr_latch_q(addr_latch_q), .prog_fetch_strobe_n_q(prog_fetch_strobe_n_q),
      .port0_float_q(port0_float_q), .port2_addr_q(port2_addr_q));

   ipm_cpu_model i_cpu (
      .sys_clk(sys_clk), .rst(rst), .irq_req_q(irq_req_q), .ack_dly(ack_dly),
      .reti_cmd(reti_cmd), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // Timer and serial sources pulse once; external pins stay low until the bench sets src back to zero
   task automatic pulse(input logic [6:0] s);
      @(posedge sys_clk);
      src <= s;
      if ((s & 7'h05) == 7'h00) begin
         @(posedge sys_clk);
         src <= 7'h00;
      end
   endtask

   task automatic none(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge sys_clk);
         #1;
         seen = seen | irq_req_q;
      end
      chk(seen, 1'b0);
   endtask

   // Offer must come inside the delay window and go once the core takes it
   task automatic take(input logic [2:0] vec, input logic [15:0] addr);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (irq_req_q !== 1'b1 && n < LMAX + 10);
      chk(n >= LMIN && n <= LMAX + 1, 1'b1);
      chk(irq_vec_q, vec);
      chk(irq_addr_q, addr);
      for (int i = 0; i < 10 && irq_req_q !== 1'b0; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk(irq_req_q, 1'b0);
   endtask

   task automatic reti;
      @(posedge sys_clk);
      reti_cmd <= 1'b1;
      @(posedge sys_clk);
      reti_cmd <= 1'b0;
   endtask

   task automatic do_reset;
      rst <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      #1;
   endtask

   // Watchdog sized well beyond the few hundred cycles of the sequence
   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end

   initial begin
      rows[0] = '{8'h81, 3'h0, `IPM_VEC_ADDR_0, 8'h00, 2'h0};
      rows[1] = '{8'h82, 3'h1, `IPM_VEC_ADDR_1, 8'h00, 2'h3};
      rows[2] = '{8'h84, 3'h2, `IPM_VEC_ADDR_2, 8'h00, 2'h0};
      rows[3] = '{8'h88, 3'h3, `IPM_VEC_ADDR_3, 8'h00, 2'h3};
      rows[4] = '{8'h90, 3'h4, `IPM_VEC_ADDR_4, 8'h10, 2'h0};
      rows[5] = '{8'h90, 3'h4, `IPM_VEC_ADDR_4, 8'h20, 2'h3};
      rows[6] = '{8'hb0, 3'h4, `IPM_VEC_ADDR_4, 8'h40, 2'h1};
      do_reset();
      chk(pins, 5'h1c);
      chk(irq_req_q, 1'b0);
      rd_chk(`IPM_ADDR_ENABLE, `IPM_RST_BYTE);
      rd_chk(4'hf, 8'h00);
      // Each source alone; enables dropped before return so serial flags stay
      for (int i = 0; i < 7; i++) begin
         wr(`IPM_ADDR_ENABLE, rows[i].en);
         ack_dly <= rows[i].dly;
         pulse(7'h01 << i);
         take(rows[i].vec, rows[i].addr);
         src <= 7'h00;
         wr(`IPM_ADDR_ENABLE, 8'h00);
         reti();
         rd_chk(`IPM_ADDR_FLAGS, rows[i].flg);
         wr(`IPM_ADDR_FLAGS, rows[i].flg);
         rd_chk(`IPM_ADDR_FLAGS, 8'h00);
      end
      // Global enable low holds back an enabled source
      wr(`IPM_ADDR_ENABLE, 8'h02);
      pulse(7'h02);
      none(LMAX + 5);
      rd_chk(`IPM_ADDR_FLAGS, 8'h02);
      wr(`IPM_ADDR_ENABLE, 8'h82);
      take(3'h1, `IPM_VEC_ADDR_1);
      reti();
      rd_chk(`IPM_ADDR_FLAGS, 8'h00);
      // Memory request without the serial enable stays silent
      wr(`IPM_ADDR_ENABLE, 8'ha0);
      pulse(7'h40);
      none(LMAX + 5);
      wr(`IPM_ADDR_FLAGS, 8'h40);
      // High preempts low; a second high waits for the return
      wr(`IPM_ADDR_PRIO, 8'h02);
      wr(`IPM_ADDR_ENABLE, 8'h8a);
      pulse(7'h08);
      take(3'h3, `IPM_VEC_ADDR_3);
      pulse(7'h02);
      take(3'h1, `IPM_VEC_ADDR_1);
      pulse(7'h02);
      none(LMAX + 5);
      rd_chk(`IPM_ADDR_STATUS, 8'h0c);
      reti();
      take(3'h1, `IPM_VEC_ADDR_1);
      reti();
      reti();
      rd_chk(`IPM_ADDR_STATUS, 8'h00);
      // Edge mode on pin A: one fall gives one request, a held-low pin no more
      wr(`IPM_ADDR_TRIG, 8'h01);
      wr(`IPM_ADDR_ENABLE, 8'h81);
      pulse(7'h01);
      take(3'h0, `IPM_VEC_ADDR_0);
      reti();
      none(LMAX + 5);
      rd_chk(`IPM_ADDR_FLAGS, 8'h00);
      src <= 7'h00;
      wr(`IPM_ADDR_TRIG, 8'h00);
      // Idle with external program memory, left by an enabled request
      ext_prog_mem <= 1'b1;
      wr(`IPM_ADDR_ENABLE, 8'h82);
      wr(`IPM_ADDR_PCTRL, 8'h01);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(pins, 5'h1f);
      chk(cpu_run_q, 1'b0);
      rd_chk(`IPM_ADDR_STATUS, 8'h01);
      pulse(7'h02);
      take(3'h1, `IPM_VEC_ADDR_1);
      chk(cpu_run_q, 1'b1);
      reti();
      // Power-down wins over idle; a request does not wake it, reset does
      wr(`IPM_ADDR_PCTRL, 8'h03);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(pins, 5'h02);
      pulse(7'h02);
      none(LMAX + 5);
      chk(pins, 5'h02);
      // Raise reset on an edge; external program memory still selected,
      // so port 2 carries address again once running
      @(posedge sys_clk);
      do_reset();
      chk(pins, 5'h1d);
      rd_chk(`IPM_ADDR_ENABLE, 8'h00);
      give_verdict();
   end
endmodule
